// ==== pkg/cms_pkg.sv ====
// package: register map, field layout and types of the counter mode sequencer
package cms_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_MODE    = 4'h0;
  localparam logic [3:0] ADDR_LOAD    = 4'h1;
  localparam logic [3:0] ADDR_HOLD    = 4'h2;
  localparam logic [3:0] ADDR_COUNT   = 4'h3;
  localparam logic [3:0] ADDR_CMD     = 4'h4;
  localparam logic [3:0] ADDR_STATUS  = 4'h5;
  localparam logic [3:0] ADDR_IRQ     = 4'h6;
  localparam logic [3:0] ADDR_MASK    = 4'h7;

  // ****************************************
  // mode word fields
  // ****************************************
  localparam int GATE_CTL_MSB = 15;
  localparam int GATE_CTL_LSB = 13;
  localparam int SPECIAL_BIT  = 7;
  localparam int RELOAD_BIT   = 6;
  localparam int REPEAT_BIT   = 5;
  localparam logic [2:0] GATE_NONE = 3'h0;

  // ****************************************
  // command and event bits
  // ****************************************
  localparam int CMD_ARM       = 0;
  localparam int CMD_DISARM    = 1;
  localparam int EV_TC         = 0;
  localparam int EV_DISARM     = 1;
  localparam int EV_CAPTURE    = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] MODE_RESET  = 16'h0000;
  localparam logic [15:0] LOAD_RESET  = 16'h0000;
  localparam logic [15:0] HOLD_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [2:0]  IRQ_RESET   = 3'h0;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } cms_bus_type;

  typedef struct packed {
    logic source;
    logic gate;
  } cms_pins_type;

  // decoded gating kind
  typedef enum logic [2:0] {
    CMS_GNONE  = 3'b001,
    CMS_GLEVEL = 3'b010,
    CMS_GEDGE  = 3'b100
  } cms_gating_type;

endpackage

// ==== design/cms_sync.sv ====
// module: three-stage pin synchroniser with second/third agreement
`timescale 1ns/1ns
module cms_sync (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } cms_sync_state_type;

  cms_sync_state_type st_q;
  cms_sync_state_type st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.lvl;
  assign rise_out  = clk_en && (st_q.s2 == st_q.s3) && st_q.s3 && !st_q.lvl;

endmodule

// ==== design/cms_counter_mode_sequencer.sv ====
// module: one counter channel, mode decode and count sequence
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ns
module cms_counter_mode_sequencer (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic         wr_en,
  input  wire logic         rd_en,
  input  wire logic [3:0]   addr,
  input  wire logic [15:0]  wdata,
  output logic      [15:0]  rdata,
  input  wire logic         source_pin,
  input  wire logic         gate_pin,
  output logic              terminal_count,
  output logic              irq
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic src_lvl;
  logic src_rise;
  logic gate_lvl;
  logic gate_rise;

  cms_sync u_src_sync (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .pin_in    (source_pin),
    .level_out (src_lvl),
    .rise_out  (src_rise)
  );

  cms_sync u_gate_sync (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .pin_in    (gate_pin),
    .level_out (gate_lvl),
    .rise_out  (gate_rise)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic cms_pkg::cms_gating_type gating_of(input logic [2:0] gc);
    if (gc == cms_pkg::GATE_NONE) begin
      return cms_pkg::CMS_GNONE;
    end else if (gc[2]) begin
      return cms_pkg::CMS_GEDGE;
    end else begin
      return cms_pkg::CMS_GLEVEL;
    end
  endfunction

  function automatic logic [15:0] dec16(input logic [15:0] v);
    return v - 16'h0001;
  endfunction

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] load;
    logic [15:0] hold;
    logic [15:0] count;
    logic        armed;
    logic        running;
    logic        in_tc;
    logic        tc_seen;
    logic        stop_pend;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [15:0] rdata;
  } cms_state_type;

  cms_state_type st_q;
  cms_state_type st_d;

  cms_pkg::cms_gating_type gating;
  logic special;
  logic reload_hold;
  logic repeat_on;
  logic src_enable;
  logic gate_hit;
  logic retrig;
  logic capture_only;
  logic alt_reload;
  logic [2:0] ev;

  always_comb begin
    gating       = gating_of(st_q.mode[cms_pkg::GATE_CTL_MSB:cms_pkg::GATE_CTL_LSB]);
    special      = st_q.mode[cms_pkg::SPECIAL_BIT];
    reload_hold  = st_q.mode[cms_pkg::RELOAD_BIT];
    repeat_on    = st_q.mode[cms_pkg::REPEAT_BIT];
    // retrigger modes N, O, Q, R: special set, reload 0, gated
    retrig       = special && !reload_hold && (gating != cms_pkg::CMS_GNONE);
    // mode X: special, reload 1, repeat 1, edge gating
    capture_only = special && reload_hold && repeat_on
                   && (gating == cms_pkg::CMS_GEDGE);
    // modes S, V: special, reload 1, no gating
    alt_reload   = special && reload_hold && (gating == cms_pkg::CMS_GNONE);
    gate_hit     = gate_rise;
    unique case (gating)
      cms_pkg::CMS_GNONE:  src_enable = st_q.armed;
      cms_pkg::CMS_GLEVEL: src_enable = st_q.armed && gate_lvl;
      cms_pkg::CMS_GEDGE:  src_enable = st_q.armed && st_q.running;
    endcase
  end

  always_comb begin
    st_d  = st_q;
    ev    = 3'h0;
    st_d.rdata = 16'h0000;

    // ---- source edge handling ----
    if (src_rise && (st_q.in_tc || src_enable)) begin
      if (st_q.in_tc) begin
        st_d.in_tc = 1'b0;
        if (st_q.stop_pend) begin
          // repetitive edge-gated modes only stop, they stay armed
          if (!repeat_on) begin
            st_d.armed             = 1'b0;
            ev[cms_pkg::EV_DISARM] = 1'b1;
          end
          st_d.running   = 1'b0;
          st_d.stop_pend = 1'b0;
        end
      end
      if (st_q.count == 16'h0001) begin
        st_d.in_tc = 1'b1;
        ev[cms_pkg::EV_TC] = 1'b1;
        if (alt_reload && gate_lvl) begin
          st_d.count = st_q.hold;
        end else begin
          st_d.count = st_q.load;
        end
        // S counts to terminal count twice before disarming
        if (!repeat_on) begin
          if (!(alt_reload && !st_q.tc_seen)) begin
            st_d.stop_pend = 1'b1;
          end
          st_d.tc_seen = !st_q.tc_seen;
        end else if (gating == cms_pkg::CMS_GEDGE && !capture_only) begin
          st_d.stop_pend = 1'b1;
        end
      end else begin
        st_d.count = dec16(st_q.count);
      end
    end

    // ---- gate edge handling ----
    if (gate_hit && st_q.armed) begin
      if (retrig) begin
        st_d.hold  = st_q.count;
        st_d.count = st_q.load;
        ev[cms_pkg::EV_CAPTURE] = 1'b1;
      end else if (capture_only) begin
        st_d.hold = st_q.count;
        ev[cms_pkg::EV_CAPTURE] = 1'b1;
      end
      if (gating == cms_pkg::CMS_GEDGE) begin
        st_d.running = 1'b1;
      end
    end

    // ---- register writes ----
    if (wr_en) begin
      unique case (addr)
        cms_pkg::ADDR_MODE:  st_d.mode = wdata; // relies on software
        cms_pkg::ADDR_LOAD:  st_d.load = wdata;
        cms_pkg::ADDR_HOLD:  st_d.hold = wdata;
        cms_pkg::ADDR_COUNT: st_d.count = wdata;
        cms_pkg::ADDR_CMD: begin
          if (wdata[cms_pkg::CMD_ARM]) begin
            st_d.armed     = 1'b1;
            st_d.stop_pend = 1'b0;
            st_d.tc_seen   = 1'b0;
          end
          if (wdata[cms_pkg::CMD_DISARM]) begin
            st_d.armed   = 1'b0;
            st_d.running = 1'b0;
          end
        end
        cms_pkg::ADDR_IRQ:   st_d.irq_stat = st_q.irq_stat & ~wdata[2:0];
        cms_pkg::ADDR_MASK:  st_d.irq_mask = wdata[2:0];
        default: ;
      endcase
    end
    // set wins over clear
    st_d.irq_stat = st_d.irq_stat | ev;

    // ---- register reads ----
    if (rd_en) begin
      unique case (addr)
        cms_pkg::ADDR_MODE:   st_d.rdata = st_q.mode;
        cms_pkg::ADDR_LOAD:   st_d.rdata = st_q.load;
        cms_pkg::ADDR_HOLD:   st_d.rdata = st_q.hold;
        cms_pkg::ADDR_COUNT:  st_d.rdata = st_q.count;
        cms_pkg::ADDR_STATUS: st_d.rdata = {11'h000, st_q.tc_seen, st_q.stop_pend,
                                            st_q.in_tc, st_q.running, st_q.armed};
        cms_pkg::ADDR_IRQ:    st_d.rdata = {13'h0000, st_q.irq_stat};
        cms_pkg::ADDR_MASK:   st_d.rdata = {13'h0000, st_q.irq_mask};
        default:              st_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q          <= '0;
      st_q.mode     <= cms_pkg::MODE_RESET;
      st_q.load     <= cms_pkg::LOAD_RESET;
      st_q.hold     <= cms_pkg::HOLD_RESET;
      st_q.count    <= cms_pkg::COUNT_RESET;
      st_q.irq_mask <= cms_pkg::IRQ_RESET;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign rdata          = st_q.rdata;
  assign terminal_count = st_q.in_tc;
  assign irq            = |(st_q.irq_stat & st_q.irq_mask);

  // ****************************************
  // assertions
  // ****************************************
  AST_TC_RELOAD_LOAD: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !wr_en && src_rise && src_enable && !st_q.in_tc && st_q.count == 16'h0001
    && !reload_hold |=> st_q.count == $past(st_q.load))
    else $error("terminal count did not reload from load");

  AST_TC_ALWAYS_COUNTS: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !wr_en && src_rise && st_q.in_tc && st_q.count != 16'h0001 |=> !st_q.in_tc)
    else $error("source edge in terminal count not counted");

  AST_ONESHOT_DISARM: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !wr_en && src_rise && st_q.in_tc && st_q.stop_pend && !repeat_on |=> !st_q.armed)
    else $error("counter not disarmed after terminal count");

  AST_REPEAT_STAYS: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !wr_en && repeat_on && st_q.armed
    |=> st_q.armed)
    else $error("repetitive counter disarmed itself");

  AST_ARM_SETS: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && wr_en && addr == cms_pkg::ADDR_CMD && wdata[0] && !wdata[1] |=> st_q.armed)
    else $error("arm command ignored");

  AST_RETRIG_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !wr_en && !src_rise && gate_rise && st_q.armed && retrig
    |=> st_q.hold == $past(st_q.count) && st_q.count == $past(st_q.load))
    else $error("retrigger did not capture and reload");

  AST_CAPTURE_CONT: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !wr_en && !src_rise && gate_rise && st_q.armed && capture_only
    |=> st_q.hold == $past(st_q.count) && $stable(st_q.count))
    else $error("mode X capture disturbed the count");

  AST_NO_COUNT_IDLE: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !wr_en && !st_q.armed && !st_q.in_tc |=> $stable(st_q.count))
    else $error("disarmed counter changed count");

  AST_GATE_IGNORED_A: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !wr_en && !src_rise && gate_rise && gating == cms_pkg::CMS_GNONE && !special
    |=> $stable(st_q.count) && $stable(st_q.hold))
    else $error("ungated mode reacted to a gate edge");

  AST_ALT_TC_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !wr_en && src_rise && (st_q.in_tc || src_enable) && st_q.count == 16'h0001
    && alt_reload && gate_lvl |=> st_q.count == $past(st_q.hold))
    else $error("terminal count with gate high did not load hold");

  AST_ALT_TC_LOAD: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !wr_en && src_rise && (st_q.in_tc || src_enable) && st_q.count == 16'h0001
    && alt_reload && !gate_lvl |=> st_q.count == $past(st_q.load))
    else $error("terminal count with gate low did not load load");

  AST_NO_RETRIG: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !wr_en && !src_rise && gate_rise && st_q.armed && special && reload_hold
    |=> $stable(st_q.count))
    else $error("non-retriggering mode restarted the count");

  AST_LEVEL_GATE_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !wr_en && gating == cms_pkg::CMS_GLEVEL && !gate_lvl && !gate_rise
    && !st_q.in_tc |=> $stable(st_q.count))
    else $error("level-gated counter counted with gate low");

endmodule

// ==== bench/cms_pin_model.sv ====
// file: partner model driving the source and gate pins
`timescale 1ns/1ns
module cms_pin_model (
  input  wire logic mclk,
  output logic      source_pin,
  output logic      gate_pin
);
  initial begin
    source_pin = 1'b0;
    gate_pin   = 1'b0;
  end
  // each level held five cycles, above the synchroniser minimum
  task automatic src(input int n);
    repeat (n) begin
      source_pin <= 1'b1;
      repeat (5) @(posedge mclk);
      source_pin <= 1'b0;
      repeat (5) @(posedge mclk);
    end
  endtask
  task automatic gate(input logic v);
    gate_pin <= v;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// ==== bench/tb.sv ====
// file: self-checking testbench of the counter mode sequencer
`timescale 1ns/1ns
module tb;
  logic        mclk;
  logic        reset_n;
  logic        clk_en;
  logic        wr_en;
  logic        rd_en;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        source_pin;
  logic        gate_pin;
  logic        terminal_count;
  logic        irq;
  logic        rd_p;
  logic [15:0] lv;
  logic [15:0] exp_q[$];
  int          fails;
  int          total_checks;
  int          seed;

  cms_counter_mode_sequencer i_cms_counter_mode_sequencer (
    .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
    .source_pin(source_pin), .gate_pin(gate_pin),
    .terminal_count(terminal_count), .irq(irq));
  cms_pin_model i_cms_pin_model (
    .mclk(mclk), .source_pin(source_pin), .gate_pin(gate_pin));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ****************************************
  // bus tasks and comparisons
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr    <= a;
    wdata   <= d;
    wr_en   <= 1'b1;
    @(posedge mclk);
    wr_en   <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t read %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_flag(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_p) begin
      chk_word(rdata, exp_q.pop_front());
    end
    rd_p <= rd_en;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    conclude;
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    seed    = 32'hf7e24f2d;
    reset_n = 1'b0;
    clk_en  = 1'b1;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    addr    = 4'h0;
    wdata   = 16'h0000;
    rd_p    = 1'b0;
    fails   = 0;
    total_checks = 0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd(cms_pkg::ADDR_MODE, cms_pkg::MODE_RESET);
    rd(cms_pkg::ADDR_COUNT, cms_pkg::COUNT_RESET);
    rd(cms_pkg::ADDR_HOLD, cms_pkg::HOLD_RESET);
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000);
    $display("test reset_values done");
    lv = 16'($random(seed));
    lv[15:8] = 8'h01;
    wr(cms_pkg::ADDR_MODE, 16'h0000);
    wr(cms_pkg::ADDR_LOAD, lv);
    wr(cms_pkg::ADDR_COUNT, 16'h0002);
    wr(cms_pkg::ADDR_MASK, 16'h0003);
    i_cms_pin_model.src(1);
    rd(cms_pkg::ADDR_COUNT, 16'h0002);
    wr(cms_pkg::ADDR_CMD, 16'h0001);
    i_cms_pin_model.gate(1'b1);
    i_cms_pin_model.gate(1'b0);
    rd(cms_pkg::ADDR_COUNT, 16'h0002);
    i_cms_pin_model.src(2);
    chk_flag(terminal_count, 1'b1);
    rd(cms_pkg::ADDR_COUNT, lv);
    i_cms_pin_model.src(2);
    rd(cms_pkg::ADDR_COUNT, lv - 16'h0001);
    chk_flag(terminal_count, 1'b0);
    rd(cms_pkg::ADDR_IRQ, 16'h0003);
    chk_flag(irq, 1'b1);
    wr(cms_pkg::ADDR_IRQ, 16'h0003);
    repeat (2) @(posedge mclk);
    chk_flag(irq, 1'b0);
    $display("test mode_a done");
    wr(cms_pkg::ADDR_MODE, 16'h00e0);
    rd(cms_pkg::ADDR_MODE, 16'h00e0);
    wr(cms_pkg::ADDR_LOAD, 16'h0004);
    wr(cms_pkg::ADDR_HOLD, 16'h0009);
    wr(cms_pkg::ADDR_COUNT, 16'h0001);
    wr(cms_pkg::ADDR_CMD, 16'h0001);
    i_cms_pin_model.gate(1'b1);
    i_cms_pin_model.src(1);
    rd(cms_pkg::ADDR_COUNT, 16'h0009);
    wr(cms_pkg::ADDR_COUNT, 16'h0001);
    i_cms_pin_model.gate(1'b0);
    i_cms_pin_model.src(1);
    rd(cms_pkg::ADDR_COUNT, 16'h0004);
    i_cms_pin_model.src(2);
    rd(cms_pkg::ADDR_COUNT, 16'h0002);
    clk_en <= 1'b0;
    i_cms_pin_model.src(1);
    wr(cms_pkg::ADDR_COUNT, 16'h00ff);
    clk_en <= 1'b1;
    rd(cms_pkg::ADDR_COUNT, 16'h0002);
    i_cms_pin_model.src(1);
    rd(cms_pkg::ADDR_COUNT, 16'h0001);
    wr(cms_pkg::ADDR_IRQ, 16'h0007);
    $display("test mode_v done");
    wr(cms_pkg::ADDR_MODE, 16'h80e0);
    wr(cms_pkg::ADDR_LOAD, 16'h0005);
    wr(cms_pkg::ADDR_COUNT, 16'h000a);
    wr(cms_pkg::ADDR_CMD, 16'h0001);
    i_cms_pin_model.gate(1'b1);
    i_cms_pin_model.src(3);
    i_cms_pin_model.gate(1'b0);
    i_cms_pin_model.gate(1'b1);
    rd(cms_pkg::ADDR_HOLD, 16'h0007);
    rd(cms_pkg::ADDR_COUNT, 16'h0007);
    rd(cms_pkg::ADDR_IRQ, 16'h0004);
    $display("test mode_x done");
    wr(cms_pkg::ADDR_MODE, 16'h2080);
    wr(cms_pkg::ADDR_LOAD, 16'h0014);
    wr(cms_pkg::ADDR_COUNT, 16'h001e);
    wr(cms_pkg::ADDR_CMD, 16'h0001);
    i_cms_pin_model.gate(1'b0);
    i_cms_pin_model.gate(1'b1);
    i_cms_pin_model.src(2);
    i_cms_pin_model.gate(1'b0);
    i_cms_pin_model.src(1);
    rd(cms_pkg::ADDR_COUNT, 16'h0012);
    i_cms_pin_model.gate(1'b1);
    rd(cms_pkg::ADDR_HOLD, 16'h0012);
    rd(cms_pkg::ADDR_COUNT, 16'h0014);
    $display("test mode_n done");
    wr(cms_pkg::ADDR_MODE, 16'h80a0);
    wr(cms_pkg::ADDR_LOAD, 16'h0002);
    wr(cms_pkg::ADDR_COUNT, 16'h0001);
    wr(cms_pkg::ADDR_CMD, 16'h0001);
    i_cms_pin_model.gate(1'b0);
    i_cms_pin_model.gate(1'b1);
    i_cms_pin_model.src(4);
    rd(cms_pkg::ADDR_COUNT, 16'h0001);
    rd(cms_pkg::ADDR_STATUS, 16'h0001);
    rd(cms_pkg::ADDR_IRQ, 16'h0005);
    wr(cms_pkg::ADDR_CMD, 16'h0002);
    rd(cms_pkg::ADDR_STATUS, 16'h0000);
    rd(cms_pkg::ADDR_MASK, 16'h0003);
    $display("test mode_r done");
    conclude;
  end
endmodule
